/* include/cdt_pkg.sv */
package cdt_pkg;

  localparam int NUM_PAIRS = 3;
  localparam int DT_W = 12;
  localparam int DT_BUS_W = 15;
  localparam logic [DT_W-1:0] DT_RESET = 12'h0fff;
  localparam logic [1:0] PRESC_DIV1 = 2'h0;

  typedef enum logic [1:0] {
    CORR_NONE = 2'h0,
    CORR_MANUAL = 2'h1,
    CORR_DEADTIME = 2'h2,
    CORR_CYCLE = 2'h3
  } corr_t;

endpackage

/* rtl/complementary_deadtime_correction.sv */
`timescale 1ns/1ps

module complementary_deadtime_correction
  import cdt_pkg::*;
#(
  parameter int PAIRS = cdt_pkg::NUM_PAIRS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [PAIRS-1:0] pair_independent_select,
  input wire logic [PAIRS-1:0] deadtime_wr,
  input wire logic [cdt_pkg::DT_W-1:0] deadtime_wdata,
  input wire logic [1:0] pwm_prescale,
  input wire logic [1:0] correction_method,
  input wire logic manual_value_select_a,
  input wire logic manual_value_select_b,
  input wire logic manual_value_select_c,
  input wire logic modulator_enable,
  input wire logic edge_aligned,
  input wire logic cycle_end,
  input wire logic half_cycle,
  input wire logic [2*PAIRS-1:0] gen_out,
  input wire logic current_sense_pin_a,
  input wire logic current_sense_pin_b,
  input wire logic current_sense_pin_c,
  output logic [2*PAIRS-1:0] pwm_out,
  output logic [PAIRS-1:0] value_select_odd,
  output logic [PAIRS-1:0] deadtime_sample_first,
  output logic [PAIRS-1:0] deadtime_sample_second,
  output logic [PAIRS-1:0] sense_gpio_in,
  output logic sense_pins_in_use
);
  import cdt_pkg::*;

  logic [DT_W-1:0] dt_reg_r [PAIRS];
  logic [DT_BUS_W-1:0] dt_cnt_r [PAIRS];
  logic [PAIRS-1:0] sense_meta_r;
  logic [PAIRS-1:0] sense_sync_r;
  logic [PAIRS-1:0] manual_vec;
  logic [PAIRS-1:0] gen_even;
  logic [PAIRS-1:0] gen_odd;
  logic [PAIRS-1:0] dt_in;
  logic [PAIRS-1:0] in_r;
  logic [PAIRS-1:0] in_q;
  logic [PAIRS-1:0] odd_in_r;
  logic [PAIRS-1:0] even_in_r;
  logic [PAIRS-1:0] chg_vec;
  logic [PAIRS-1:0] busy;
  logic [PAIRS-1:0] busy_q;
  logic [PAIRS-1:0] dt_end;
  logic [PAIRS-1:0] top_r;
  logic [PAIRS-1:0] bot_r;
  logic [PAIRS-1:0] sel_odd_r;
  logic [PAIRS-1:0] latch_r;
  logic enable_q;
  logic en_rise;
  corr_t method;

  // Bus clocks of deadtime less the toggle cycle itself, and one clock fewer again when prescaled, never below zero
  function automatic logic [DT_BUS_W-1:0] dt_load(
    input logic [DT_W-1:0] count,
    input logic [1:0] presc
  );
    logic [DT_BUS_W-1:0] total;
    total = DT_BUS_W'({3'h0, count} << presc);
    if (presc != PRESC_DIV1 && total != '0) begin
      total = total - 1'b1;
    end
    return (total == '0) ? '0 : total - 1'b1;
  endfunction

  assign method = corr_t'(correction_method);
  assign manual_vec = {manual_value_select_c, manual_value_select_b,
                       manual_value_select_a};
  assign en_rise = modulator_enable & ~enable_q;
  assign sense_gpio_in = sense_sync_r;
  assign sense_pins_in_use = (method != CORR_NONE);
  assign value_select_odd = sel_odd_r;

  always_comb begin
    for (int p = 0; p < PAIRS; p++) begin
      gen_even[p] = gen_out[2*p];
      gen_odd[p] = gen_out[2*p+1];
      // Only one value generator feeds a complementary pair at a time
      dt_in[p] = sel_odd_r[p] ? gen_odd[p] : gen_even[p];
      chg_vec[p] = (in_r[p] ^ in_q[p]) & ~pair_independent_select[p];
      busy[p] = chg_vec[p] | (dt_cnt_r[p] != '0);
      dt_end[p] = busy_q[p] & ~busy[p] & ~pair_independent_select[p];
      pwm_out[2*p] = top_r[p];
      pwm_out[2*p+1] = bot_r[p];
    end
  end

  // Pins are asynchronous to the bus clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sense_meta_r <= '0;
      sense_sync_r <= '0;
    end else begin
      sense_meta_r <= {current_sense_pin_c, current_sense_pin_b,
                       current_sense_pin_a};
      sense_sync_r <= sense_meta_r;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < PAIRS; p++) begin
        dt_reg_r[p] <= DT_RESET;
      end
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (deadtime_wr[p]) begin
          dt_reg_r[p] <= deadtime_wdata;
        end
      end
    end
  end

  // First pipeline stage of the two-cycle output path
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      in_r <= '0;
      in_q <= '0;
      odd_in_r <= '0;
      even_in_r <= '0;
      busy_q <= '0;
    end else begin
      in_r <= dt_in;
      in_q <= in_r;
      odd_in_r <= gen_odd;
      // Independent top ignores the correction choice of odd or even
      even_in_r <= gen_even;
      busy_q <= busy;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < PAIRS; p++) begin
        dt_cnt_r[p] <= '0;
      end
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (chg_vec[p]) begin
          // Reload on every toggle of a complementary pair, even mid deadtime
          dt_cnt_r[p] <= dt_load(dt_reg_r[p], pwm_prescale);
        end else if (dt_cnt_r[p] != '0) begin
          dt_cnt_r[p] <= dt_cnt_r[p] - 1'b1;
        end
      end
    end
  end

  // Second stage drives the pins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      top_r <= '0;
      bot_r <= '0;
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (pair_independent_select[p]) begin
          top_r[p] <= even_in_r[p];
          bot_r[p] <= odd_in_r[p];
        end else begin
          // Both off during deadtime, otherwise complements
          top_r[p] <= in_r[p] & ~busy[p];
          bot_r[p] <= ~in_r[p] & ~busy[p];
        end
      end
    end
  end

  // First sample precedes top assertion, second precedes bottom
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      deadtime_sample_first <= '0;
      deadtime_sample_second <= '0;
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (dt_end[p] && in_r[p]) begin
          deadtime_sample_first[p] <= sense_sync_r[p];
        end
        if (dt_end[p] && !in_r[p]) begin
          deadtime_sample_second[p] <= sense_sync_r[p];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= modulator_enable;
    end
  end

  // Latched sense state waits for the next cycle end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latch_r <= '1;
    end else if (!modulator_enable || en_rise) begin
      latch_r <= '1;
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (method == CORR_DEADTIME && dt_end[p]) begin
          // No deadtime at 0% or 100%, so nothing new is taken
          latch_r[p] <= sense_sync_r[p];
        end else if (method == CORR_CYCLE && !edge_aligned && half_cycle) begin
          latch_r[p] <= sense_sync_r[p];
        end
      end
    end
  end

  // Selection changes only at cycle end or on enable rise with a sense method, load okay plays no part
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_odd_r <= '0;
    end else if (en_rise && correction_method[1]) begin
      sel_odd_r <= '1;
    end else if (cycle_end) begin
      unique case (method)
        CORR_NONE: sel_odd_r <= '0;
        CORR_MANUAL: sel_odd_r <= manual_vec;
        CORR_DEADTIME: sel_odd_r <= latch_r;
        CORR_CYCLE: sel_odd_r <= edge_aligned ? sense_sync_r : latch_r;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_toggle;
    chg_vec != '0;
  endsequence

  sequence s_cycle_point;
    cycle_end && !en_rise;
  endsequence

  property p_indep;
    ((top_r ^ $past(gen_even, 2)) & pair_independent_select &
     $past(pair_independent_select, 2)) == '0;
  endproperty
  a_indep: assert property (p_indep)
    else $error("independent top output does not follow its generator");

  property p_no_overlap;
    (top_r & bot_r & ~$past(pair_independent_select)) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("top and bottom active together");

  property p_dt_off;
    s_toggle |=> ((top_r | bot_r) & $past(chg_vec)) == '0;
  endproperty
  a_dt_off: assert property (p_dt_off)
    else $error("output active right after a deadtime toggle");

  property p_delay;
    (top_r & ~$past(pair_independent_select) & ~$past(dt_in, 2)) == '0;
  endproperty
  a_delay: assert property (p_delay)
    else $error("top active without generator high two cycles before");

  property p_sel_hold;
    !$past(cycle_end) && !$past(en_rise) |-> $stable(sel_odd_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("value selection changed mid period");

  property p_manual;
    s_cycle_point ##0 (method == CORR_MANUAL) |=>
      sel_odd_r == $past(manual_vec);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual selection not applied at cycle end");

  property p_none;
    s_cycle_point ##0 (method == CORR_NONE) |=> sel_odd_r == '0;
  endproperty
  a_none: assert property (p_none)
    else $error("even values not used without correction");

  property p_init_odd;
    en_rise && correction_method[1] |=> sel_odd_r == '1 && latch_r == '1;
  endproperty
  a_init_odd: assert property (p_init_odd)
    else $error("odd values not in control after enable");

  property p_dt_hold;
    !$past(deadtime_wr[0]) |-> $stable(dt_reg_r[0]);
  endproperty
  a_dt_hold: assert property (p_dt_hold)
    else $error("deadtime register changed without a write");

endmodule // complementary_deadtime_correction

/* tb/sense_partner.sv */
`timescale 1ns/1ps

module sense_partner (
  input wire logic [5:0] pwm_out,
  input wire logic [1:0] load_mode,
  output logic current_sense_pin_a,
  output logic current_sense_pin_b,
  output logic current_sense_pin_c
);
  logic [2:0] node_high_r = 3'h0;
  logic [2:0] pin;

  // Node keeps the last driven level while both switches are off
  always @(pwm_out) begin
    for (int p = 0; p < 3; p++) begin
      if (pwm_out[2*p]) node_high_r[p] = 1'b1;
      else if (pwm_out[2*p+1]) node_high_r[p] = 1'b0;
    end
  end

  // Mode 0 outflow, 1 inflow, 2 low current floating the node
  always_comb begin
    if (load_mode == 2'h0) pin = 3'h0;
    else if (load_mode == 2'h1) pin = 3'h7;
    else pin = node_high_r;
  end

  assign current_sense_pin_a = pin[0];
  assign current_sense_pin_b = pin[1];
  assign current_sense_pin_c = pin[2];
endmodule // sense_partner

/* tb/test_complementary_deadtime_correction.sv */
`timescale 1ns/1ps

module test_complementary_deadtime_correction;
  import cdt_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] pair_independent_select, deadtime_wr, value_select_odd;
  logic [2:0] deadtime_sample_first, deadtime_sample_second, sense_gpio_in;
  logic [11:0] deadtime_wdata;
  logic [1:0] pwm_prescale, correction_method, load_mode;
  logic manual_value_select_a, manual_value_select_b, manual_value_select_c;
  logic modulator_enable, edge_aligned, cycle_end, half_cycle;
  logic current_sense_pin_a, current_sense_pin_b, current_sense_pin_c;
  logic [5:0] gen_out, pwm_out;
  logic sense_pins_in_use;
  int err_total = 0;
  int num_checks = 0;

  complementary_deadtime_correction dut_u (.*);
  sense_partner load_u (.*);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp,
                          input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic write_dt(input logic [11:0] cnt);
    deadtime_wdata = cnt;
    deadtime_wr = 3'h1;
    tick();
    deadtime_wr = 3'h0;
  endtask

  task automatic settle();
    gen_out = 6'h00;
    repeat (60) tick();
  endtask

  task automatic pulse_end();
    tick();
    cycle_end = 1'b1;
    tick();
    cycle_end = 1'b0;
  endtask

  // Toggle pair 0 input, count edges until the target switch turns on
  // Count is the deadtime plus the two edges of the output path
  task automatic edge_wait(input logic lvl, input int exp);
    int n;
    n = 0;
    gen_out[1:0] = {2{lvl}};
    while (pwm_out[lvl ? 0 : 1] !== 1'b1 && n < 5000) begin
      tick();
      n++;
      chk_bits(pwm_out[0] & pwm_out[1], 6'h00, "overlap");
      if (n == 2) chk_bits(pwm_out[1:0], 6'h00, "not off");
    end
    chk_num(n, exp, "deadtime length");
  endtask

  task automatic t_reset();
    chk_bits(pwm_out, 6'h00, "reset out");
    chk_bits({deadtime_sample_first, deadtime_sample_second}, 6'h00,
             "smp");
    for (int m = 0; m < 4; m++) begin
      correction_method = 2'(m);
      tick();
      chk_bits(6'(sense_pins_in_use), 6'(m != 0), "pins use");
    end
    correction_method = CORR_NONE;
    pair_independent_select = 3'h6;
    edge_wait(1'b1, int'(DT_RESET) + 2);
  endtask

  task automatic t_indep();
    pair_independent_select = 3'h7;
    gen_out = 6'h00;
    repeat (4) tick();
    gen_out = 6'h02;
    tick();
    chk_bits(pwm_out, 6'h00, "early");
    tick();
    chk_bits(pwm_out, 6'h02, "odd alone");
    gen_out = 6'h23;
    repeat (2) tick();
    chk_bits(pwm_out, 6'h23, "both high");
  endtask

  task automatic t_deadtime();
    int t;
    pair_independent_select = 3'h6;
    for (int p = 0; p < 4; p++) begin
      pwm_prescale = 2'(p);
      write_dt(12'h005);
      settle();
      t = (p == 0) ? 5 : 5 * (1 << p) - 1;
      edge_wait(1'b1, t + 2);
      edge_wait(1'b0, t + 2);
    end
  endtask

  // Second and third toggle land inside the running deadtime
  task automatic t_restart();
    pwm_prescale = 2'h0;
    write_dt(12'h003);
    settle();
    gen_out[1:0] = 2'b11;
    repeat (2) tick();
    gen_out[1:0] = 2'b00;
    repeat (2) tick();
    edge_wait(1'b1, 5);
  endtask

  task automatic t_samples();
    logic [1:0] e;
    write_dt(12'h006);
    for (int m = 0; m < 3; m++) begin
      load_mode = 2'(m);
      e = {m == 1, m != 0};
      settle();
      edge_wait(1'b1, 8);
      repeat (20) tick();
      edge_wait(1'b0, 8);
      repeat (20) tick();
      chk_bits({deadtime_sample_first[0], deadtime_sample_second[0]}, e,
               "samples");
    end
  endtask

  task automatic t_select();
    correction_method = CORR_MANUAL;
    {manual_value_select_c, manual_value_select_b, manual_value_select_a} =
      3'b101;
    repeat (3) tick();
    chk_bits(value_select_odd, 6'h00, "mid period");
    pulse_end();
    chk_bits(value_select_odd, 6'h05, "manual");
    gen_out = 6'h10;
    repeat (2) tick();
    chk_bits(pwm_out, 6'h12, "indep even top");
    {manual_value_select_c, manual_value_select_b, manual_value_select_a} =
      3'b010;
    pulse_end();
    chk_bits(value_select_odd, 6'h02, "manual again");
    correction_method = CORR_NONE;
    load_mode = 2'h1;
    repeat (4) tick();
    pulse_end();
    chk_bits(value_select_odd, 6'h00, "none");
    chk_bits(sense_gpio_in, 6'h07, "gpio");
    correction_method = CORR_CYCLE;
    pulse_end();
    chk_bits(value_select_odd, 6'h07, "cycle in");
    load_mode = 2'h0;
    repeat (4) tick();
    pulse_end();
    chk_bits(value_select_odd, 6'h00, "cycle out");
    correction_method = CORR_DEADTIME;
    modulator_enable = 1'b1;
    tick();
    chk_bits(value_select_odd, 6'h07, "enable odd");
    edge_wait(1'b1, 8);
    repeat (10) tick();
    pulse_end();
    chk_bits(value_select_odd, 6'h06, "dt latch");
    load_mode = 2'h1;
    repeat (10) tick();
    pulse_end();
    chk_bits(value_select_odd, 6'h06, "full duty");
    // Center aligned: the half cycle sample wins over the pin at cycle end
    correction_method = CORR_CYCLE;
    edge_aligned = 1'b0;
    load_mode = 2'h0;
    repeat (4) tick();
    half_cycle = 1'b1;
    tick();
    half_cycle = 1'b0;
    load_mode = 2'h1;
    repeat (4) tick();
    pulse_end();
    chk_bits(value_select_odd, 6'h00, "center half");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    pair_independent_select = 3'h7;
    deadtime_wr = 3'h0;
    deadtime_wdata = 12'h000;
    pwm_prescale = 2'h0;
    correction_method = 2'h0;
    load_mode = 2'h0;
    {manual_value_select_c, manual_value_select_b, manual_value_select_a} =
      3'h0;
    modulator_enable = 1'b0;
    edge_aligned = 1'b1;
    cycle_end = 1'b0;
    half_cycle = 1'b0;
    gen_out = 6'h00;
    repeat (3) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_indep();
    t_deadtime();
    t_restart();
    t_samples();
    t_select();
    end_sim();
  end
endmodule // test_complementary_deadtime_correction
